// file: lst_consts.svh
// Constants of the logic self-test controller
`ifndef LST_CONSTS_SVH
`define LST_CONSTS_SVH
`define LST_CLK_PERIOD_NS 10
`define LST_TIMEOUT_US    100
`define LST_CORE_RST_NS   100
`define LST_NCPU          2
`define LST_CHAINS        16
`define LST_CHAIN_LEN     64
`define LST_CNT_W         16
`define LST_IRQ_W         8
`define LST_NDOM          6
`define LST_DOM_COVERED   6'h3F
`define LST_PRPG_POLY     16'hB400
`define LST_MISR_POLY     16'hD008
`define LST_SIG_RESET     16'h0000
`endif

// file: lst_pkg.sv
// Types shared by the logic self-test controller
package lst_pkg;
    typedef enum logic [2:0] {
        LST_ST_IDLE,
        LST_ST_PREP,
        LST_ST_SHIFT,
        LST_ST_CAPTURE,
        LST_ST_COMPARE,
        LST_ST_CORE_RST
    } lst_state_type;

    // Scan domains, one scan enable each
    typedef enum logic [2:0] {
        LST_DOM_CORE,
        LST_DOM_FLOAT,
        LST_DOM_COMPLEX,
        LST_DOM_CRC,
        LST_DOM_TRIG,
        LST_DOM_EMU
    } lst_domain_type;

    typedef struct packed {
        logic start;
        logic restart;
        logic log_clr;
    } lst_cmd_type;

    typedef struct packed {
        logic busy;
        logic run_done;
        logic all_done;
        logic fail_logic;
        logic fail_timeout;
    } lst_status_type;
endpackage

// file: lst_sig_lfsr.sv
// Galois shift register used as pattern generator and as signature register
`timescale 1ns/1ps
`include "lst_consts.svh"
module lst_sig_lfsr #(
    parameter int           W    = `LST_CHAINS,
    parameter logic [W-1:0] POLY = `LST_PRPG_POLY
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic [W-1:0] seed,
    input  wire logic         step,
    input  wire logic         absorb,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] sig;
    } lst_lfsr_state_type;

    lst_lfsr_state_type s_ff;
    lst_lfsr_state_type nxt_s;

    generate
        if (W < 2 || POLY[W-1] != 1'b1) begin : g_bad
            $error("lst_sig_lfsr: width below 2 or polynomial without top tap");
        end
    endgenerate

    // An all-zero seed locks the generator; software must avoid it
    always_comb begin
        nxt_s = s_ff;
        if (load) begin
            nxt_s.sig = seed;
        end else if (step) begin
            nxt_s.sig = {s_ff.sig[W-2:0], 1'b0} ^ (s_ff.sig[W-1] ? POLY : '0) ^ (absorb ? din : '0);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.sig;
endmodule

// file: lst_top.sv
// Sequencer of the scan-based logic self-test of the processor core
//
// Functional notes
// R1 - All shift and capture timing runs on the one system clock, no test clock.
// R2 - Controller decides when chains shift and when the capture pulse fires.
// R3 - Controller loads seeds and the expected signature for the final compare.
// R4 - Pattern generator drives a seed bit into every parallel scan chain.
// R5 - Signature register compacts every chain output for the expected compare.
// R6 - Full pattern set runs as a series of short micro-runs.
// R7 - During a micro-run the core is isolated from peripherals and memory.
// R8 - Interrupts during a micro-run are logged, not delivered to the core.
// R9 - After a micro-run peripheral and interrupt connections return to normal.
// R10 - Test covers core, its accelerators and emulation analysis logic.
// R11 - No logic outside the core and accelerators is scanned; the code also enables the emulation domain (LST_DOM_EMU).
// R12 - Nothing relies on latch content surviving a micro-run.
// R13 - Software saves and restores core context around each micro-run.
// R14 - Semaphore gives one core at a time write access to the controls.
// R15 - In manufacturing an external tester configures through the test port; the code has no test port, configuration comes only through cfg_wr.
// R16 - Logic failure sets status, raises a non-maskable interrupt and its flags.
// R17 - Micro-run timeout reports an error like a logic failure.
// R18 - Each micro-run ends with a reset to the tested core.
// R19 - On two processors a failure interrupts each processor.
// R20 - Pattern position is kept between micro-runs until the set is done.
// R21 - Busy and run-done status tell software the outcome of each run.
`timescale 1ns/1ps
`include "lst_consts.svh"
module lst_top
    import lst_pkg::*;
#(
    parameter int NCPU        = `LST_NCPU,
    parameter int CHAINS      = `LST_CHAINS,
    parameter int CHAIN_LEN   = `LST_CHAIN_LEN,
    parameter int IRQ_W       = `LST_IRQ_W,
    parameter int TIMEOUT_CYC = (`LST_TIMEOUT_US * 1000) / `LST_CLK_PERIOD_NS,
    parameter logic [CHAINS-1:0] PRPG_POLY = `LST_PRPG_POLY,
    parameter logic [CHAINS-1:0] MISR_POLY = `LST_MISR_POLY
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic        [NCPU-1:0]       sem_req,
    input  wire logic        [NCPU-1:0]       sem_rel,
    input  wire logic        [NCPU-1:0]       cfg_wr,
    input  wire logic        [CHAINS-1:0]     cfg_seed,
    input  wire logic        [CHAINS-1:0]     cfg_expect,
    input  wire logic        [`LST_CNT_W-1:0] cfg_run_pat,
    input  wire logic        [`LST_CNT_W-1:0] cfg_total_pat,
    input  wire lst_pkg::lst_cmd_type [NCPU-1:0] cmd,
    input  wire logic        [NCPU-1:0]       nmi_clr,
    input  wire logic        [IRQ_W-1:0]      irq_in,
    input  wire logic        [CHAINS-1:0]     scan_out,
    output logic             [NCPU-1:0]       sem_owner,
    output logic             [CHAINS-1:0]     scan_in,
    output logic             [`LST_NDOM-1:0]  scan_en,
    output logic                              capture_en,
    output logic                              core_isolate,
    output logic                              core_rst,
    output logic             [IRQ_W-1:0]      core_irq,
    output logic             [IRQ_W-1:0]      irq_log,
    output logic             [NCPU-1:0]       nmi,
    output lst_pkg::lst_status_type           status
);
    import lst_pkg::*;

    localparam int CW      = `LST_CNT_W;
    localparam int SW      = $clog2(CHAIN_LEN + 1);
    localparam int TW      = $clog2(TIMEOUT_CYC + 1);
    localparam int RST_CYC = (`LST_CORE_RST_NS + `LST_CLK_PERIOD_NS - 1) / `LST_CLK_PERIOD_NS;
    localparam int RW      = $clog2(RST_CYC + 1);
    localparam logic [SW-1:0] SHIFT_LAST = SW'(CHAIN_LEN - 1);
    localparam logic [TW-1:0] TMO_LAST   = TW'(TIMEOUT_CYC - 1);
    localparam logic [RW-1:0] RST_LAST   = RW'(RST_CYC - 1);
    localparam logic [`LST_NDOM-1:0] DOM_MASK = `LST_DOM_COVERED;

    generate
        if (NCPU < 1 || NCPU > 2 || CHAIN_LEN < 2 || TIMEOUT_CYC < 2 || RST_CYC < 1 || IRQ_W < 1) begin : g_bad
            $error("lst_top: parameter out of range");
        end
    endgenerate

    typedef struct packed {
        lst_state_type        st;
        logic [SW-1:0]        shift_cnt;
        logic                 unload;
        logic [CW-1:0]        pos;
        logic [CW-1:0]        run_cnt;
        logic [TW-1:0]        tmo_cnt;
        logic [RW-1:0]        rst_cnt;
        logic [NCPU-1:0]      owner;
        logic [CHAINS-1:0]    seed;
        logic [CHAINS-1:0]    expect_sig;
        logic [CW-1:0]        run_pat;
        logic [CW-1:0]        total_pat;
        logic                 prpg_load;
        logic                 misr_clr;
        logic [`LST_NDOM-1:0] scan_en;
        logic                 cap_en;
        logic                 isolate;
        logic                 core_rst;
        logic [IRQ_W-1:0]     irq_log;
        logic [IRQ_W-1:0]     core_irq;
        logic [NCPU-1:0]      nmi;
        lst_status_type       status;
    } lst_core_state_type;

    lst_core_state_type s_ff;
    lst_core_state_type nxt_s;

    logic [CHAINS-1:0] prpg_q;
    logic [CHAINS-1:0] misr_q;
    logic              shifting;

    function automatic logic [NCPU-1:0] lowest_one(input logic [NCPU-1:0] v);
        logic [NCPU-1:0] r;
        logic            found;
        r = '0;
        found = 1'b0;
        for (int i = 0; i < NCPU; i++) begin
            if (v[i] && !found) begin
                r[i] = 1'b1;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic lst_cmd_type owner_cmd(input lst_cmd_type [NCPU-1:0] c, input logic [NCPU-1:0] own);
        lst_cmd_type r;
        r = '0;
        for (int i = 0; i < NCPU; i++) begin
            if (own[i]) begin
                r = r | c[i];
            end
        end
        return r;
    endfunction

    assign shifting = |s_ff.scan_en;

    // Pattern generator feeds one bit into every chain while shifting
    lst_sig_lfsr #(
        .W    (CHAINS),
        .POLY (PRPG_POLY)
    ) u_prpg (
        .clk    (clk),
        .rst_b  (rst_b),
        .load   (s_ff.prpg_load),
        .seed   (s_ff.seed),
        .step   (shifting),
        .absorb (1'b0),
        .din    ('0),
        .q      (prpg_q)
    ); // [R4] [R1]

    // Signature register absorbs all chain outputs on every shift
    lst_sig_lfsr #(
        .W    (CHAINS),
        .POLY (MISR_POLY)
    ) u_misr (
        .clk    (clk),
        .rst_b  (rst_b),
        .load   (s_ff.misr_clr),
        .seed   (`LST_SIG_RESET),
        .step   (shifting),
        .absorb (1'b1),
        .din    (scan_out),
        .q      (misr_q)
    ); // [R5] [R1]

    always_comb begin
        lst_cmd_type c;
        logic        wr_ok;
        logic        fail;
        c = owner_cmd(cmd, s_ff.owner);
        wr_ok = (cfg_wr & s_ff.owner) != '0;
        fail = 1'b0;
        nxt_s = s_ff;
        nxt_s.prpg_load = 1'b0;
        nxt_s.misr_clr = 1'b0;
        nxt_s.cap_en = 1'b0;

        // Release waits for idle so a run never changes hands midway
        if (s_ff.owner == '0) begin
            nxt_s.owner = lowest_one(sem_req); // [R14]
        end else if ((sem_rel & s_ff.owner) != '0 && s_ff.st == LST_ST_IDLE) begin
            nxt_s.owner = '0; // [R14]
        end
        if (wr_ok && s_ff.st == LST_ST_IDLE) begin
            nxt_s.seed = cfg_seed; // [R3] [R14]
            nxt_s.expect_sig = cfg_expect; // [R3]
            nxt_s.run_pat = cfg_run_pat; // [R6]
            nxt_s.total_pat = cfg_total_pat;
        end

        // Logged interrupts are replayed once the core is released
        nxt_s.irq_log = (s_ff.irq_log & ~{IRQ_W{c.log_clr}}) | (s_ff.isolate ? irq_in : '0); // [R8]
        nxt_s.core_irq = s_ff.isolate ? '0 : (irq_in | s_ff.irq_log); // [R8] [R9]

        if (s_ff.st != LST_ST_IDLE && s_ff.st != LST_ST_CORE_RST) begin
            nxt_s.tmo_cnt = s_ff.tmo_cnt + TW'(1);
        end

        unique case (s_ff.st)
            LST_ST_IDLE: begin
                if (c.start) begin
                    nxt_s.isolate = 1'b1; // [R7]
                    nxt_s.status.busy = 1'b1; // [R21]
                    nxt_s.status.run_done = 1'b0;
                    nxt_s.run_cnt = '0;
                    nxt_s.tmo_cnt = '0;
                    nxt_s.unload = 1'b0;
                    // Fresh set reseeds; otherwise continue from kept position
                    if (c.restart || s_ff.status.all_done) begin
                        nxt_s.pos = '0; // [R20]
                        nxt_s.prpg_load = 1'b1; // [R3] [R12]
                        nxt_s.misr_clr = 1'b1;
                        nxt_s.status.all_done = 1'b0;
                        nxt_s.status.fail_logic = 1'b0;
                        nxt_s.status.fail_timeout = 1'b0;
                    end
                    nxt_s.st = LST_ST_PREP;
                end
            end
            LST_ST_PREP: begin
                nxt_s.shift_cnt = '0;
                nxt_s.scan_en = DOM_MASK; // [R2] [R10] [R11]
                nxt_s.st = LST_ST_SHIFT;
            end
            LST_ST_SHIFT: begin
                nxt_s.shift_cnt = s_ff.shift_cnt + SW'(1);
                if (s_ff.shift_cnt == SHIFT_LAST) begin
                    nxt_s.scan_en = '0; // [R2]
                    if (s_ff.unload) begin
                        nxt_s.st = LST_ST_COMPARE;
                    end else begin
                        nxt_s.cap_en = 1'b1; // [R2] [R1]
                        nxt_s.st = LST_ST_CAPTURE;
                    end
                end
            end
            LST_ST_CAPTURE: begin
                nxt_s.pos = s_ff.pos + CW'(1); // [R20]
                nxt_s.run_cnt = s_ff.run_cnt + CW'(1);
                nxt_s.shift_cnt = '0;
                if (s_ff.pos + CW'(1) >= s_ff.total_pat) begin
                    // Last capture still has to be shifted into the signature
                    nxt_s.unload = 1'b1;
                    nxt_s.scan_en = DOM_MASK; // [R5]
                    nxt_s.st = LST_ST_SHIFT;
                end else if (s_ff.run_cnt + CW'(1) == s_ff.run_pat) begin
                    nxt_s.rst_cnt = '0;
                    nxt_s.core_rst = 1'b1; // [R6] [R18]
                    nxt_s.st = LST_ST_CORE_RST;
                end else begin
                    nxt_s.scan_en = DOM_MASK;
                    nxt_s.st = LST_ST_SHIFT;
                end
            end
            LST_ST_COMPARE: begin
                nxt_s.status.all_done = 1'b1;
                if (misr_q != s_ff.expect_sig) begin
                    nxt_s.status.fail_logic = 1'b1; // [R16] [R5]
                    fail = 1'b1;
                end
                nxt_s.rst_cnt = '0;
                nxt_s.core_rst = 1'b1; // [R18] [R12]
                nxt_s.st = LST_ST_CORE_RST;
            end
            LST_ST_CORE_RST: begin
                nxt_s.rst_cnt = s_ff.rst_cnt + RW'(1);
                if (s_ff.rst_cnt == RST_LAST) begin
                    nxt_s.core_rst = 1'b0; // [R18]
                    nxt_s.isolate = 1'b0; // [R9] [R7]
                    nxt_s.status.busy = 1'b0; // [R21]
                    nxt_s.status.run_done = 1'b1; // [R21]
                    nxt_s.st = LST_ST_IDLE;
                end
            end
        endcase

        // Watchdog wins over the normal flow of the micro-run
        if (s_ff.st != LST_ST_IDLE && s_ff.st != LST_ST_CORE_RST && s_ff.tmo_cnt == TMO_LAST) begin
            nxt_s.status.fail_timeout = 1'b1; // [R17]
            fail = 1'b1;
            nxt_s.scan_en = '0;
            nxt_s.cap_en = 1'b0;
            nxt_s.rst_cnt = '0;
            nxt_s.core_rst = 1'b1; // [R18]
            nxt_s.st = LST_ST_CORE_RST;
        end

        // A new failure outranks a clear in the same cycle
        nxt_s.nmi = (s_ff.nmi & ~nmi_clr) | {NCPU{fail}}; // [R16] [R19] [R17]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s; // [R1]
        end
    end

    assign sem_owner    = s_ff.owner;
    assign scan_in      = prpg_q;
    assign scan_en      = s_ff.scan_en;
    assign capture_en   = s_ff.cap_en;
    assign core_isolate = s_ff.isolate;
    assign core_rst     = s_ff.core_rst;
    assign core_irq     = s_ff.core_irq;
    assign irq_log      = s_ff.irq_log;
    assign nmi          = s_ff.nmi;
    assign status       = s_ff.status;
endmodule

// file: lst_top_asserts.sv
// Port-level checks of the logic self-test sequencer
`timescale 1ns/1ps
`include "lst_consts.svh"
module lst_top_asserts
    import lst_pkg::*;
#(
    parameter int NCPU      = 2,
    parameter int CHAINS    = 16,
    parameter int CHAIN_LEN = 64,
    parameter int IRQ_W     = 8
) (
    input wire logic                                 clk,
    input wire logic                                 rst_b,
    input wire logic        [NCPU-1:0]               sem_owner,
    input wire lst_pkg::lst_cmd_type [NCPU-1:0]      cmd,
    input wire logic        [IRQ_W-1:0]              irq_in,
    input wire logic        [CHAINS-1:0]             scan_in,
    input wire logic        [`LST_NDOM-1:0]          scan_en,
    input wire logic                                 capture_en,
    input wire logic                                 core_isolate,
    input wire logic                                 core_rst,
    input wire logic        [IRQ_W-1:0]              core_irq,
    input wire logic        [IRQ_W-1:0]              irq_log,
    input wire logic        [NCPU-1:0]               nmi,
    input wire lst_pkg::lst_status_type              status
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    localparam int RST_CYC = (`LST_CORE_RST_NS + `LST_CLK_PERIOD_NS - 1) / `LST_CLK_PERIOD_NS;
    logic [15:0] shift_cnt_ff;
    logic [15:0] rst_cnt_ff;
    // Length of the current core reset pulse, counted instead of a long repetition
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt_ff <= 16'h0000;
        end else begin
            rst_cnt_ff <= core_rst ? rst_cnt_ff + 16'h0001 : 16'h0000;
        end
    end
    // Run length of the current shift burst
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_cnt_ff <= 16'h0000;
        end else begin
            shift_cnt_ff <= (scan_en != '0) ? shift_cnt_ff + 16'h0001 : 16'h0000;
        end
    end
    shift_len_a: assert property (capture_en |-> shift_cnt_ff == CHAIN_LEN)
        else $error("capture not after a full shift burst");
    all_dom_a: assert property (scan_en == '0 || scan_en == `LST_DOM_COVERED)
        else $error("partial domain scan enable");
    scan_iso_a: assert property (scan_en != '0 |-> core_isolate)
        else $error("scan while core connected");
    gen_step_a: assert property (scan_en != '0 |=> scan_in != $past(scan_in))
        else $error("generator did not step");
    irq_block_a: assert property (core_isolate && $past(core_isolate) |-> core_irq == '0)
        else $error("interrupt reached isolated core");
    irq_log_a: assert property (core_isolate && !core_rst |=> (irq_log & $past(irq_in)) == $past(irq_in))
        else $error("interrupt not logged");
    irq_pass_a: assert property (!$past(core_isolate) && !core_isolate |-> core_irq == $past(irq_in | irq_log))
        else $error("interrupt not delivered after release");
    rst_len_a: assert property ($fell(core_rst) |-> rst_cnt_ff == RST_CYC)
        else $error("core reset length wrong");
    rst_max_a: assert property (core_rst |-> rst_cnt_ff < RST_CYC)
        else $error("core reset held too long");
    rst_end_a: assert property ($fell(core_rst) |-> !core_isolate && !status.busy)
        else $error("run not closed with core reset");
    start_go_a: assert property (cmd[0].start && sem_owner[0] && !status.busy |=> status.busy && core_isolate)
        else $error("start not taken");
    fail_nmi_a: assert property ($rose(status.fail_timeout) |-> nmi == '1)
        else $error("timeout without interrupt to all");
    sem_one_a: assert property ($onehot0(sem_owner))
        else $error("two owners");
    cover property (capture_en);
    cover property ($rose(status.all_done));
    cover property ($rose(status.fail_timeout));
endmodule

bind lst_top lst_top_asserts #(.NCPU(NCPU), .CHAINS(CHAINS), .CHAIN_LEN(CHAIN_LEN), .IRQ_W(IRQ_W))
    u_lst_top_asserts (.clk, .rst_b, .sem_owner, .cmd, .irq_in, .scan_in, .scan_en, .capture_en,
    .core_isolate, .core_rst, .core_irq, .irq_log, .nmi, .status);

// file: lst_core_model.sv
// Behavioural scan chains of the core under test
`timescale 1ns/1ps
`include "lst_consts.svh"
module lst_core_model #(
    parameter int CHAINS = 16
) (
    input  wire logic [CHAINS-1:0]    scan_in,
    input  wire logic [`LST_NDOM-1:0] scan_en,
    input  wire logic                 clk,
    output logic      [CHAINS-1:0]    scan_out
);
    initial scan_out = '0;
    // Idle chains toggle so stale data never looks like a result
    always @(posedge clk) begin
        if (scan_en != '0) begin
            scan_out <= scan_in;
        end else begin
            scan_out <= ~scan_out;
        end
    end
endmodule

// file: tb_top.sv
// Self-checking bench of the logic self-test sequencer
`timescale 1ns/1ps
module tb_top;
    import lst_pkg::*;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic [1:0]            sem_req = '0, sem_rel = '0, cfg_wr = '0, nmi_clr = '0;
    logic [15:0]           cfg_seed = 16'hACE1, cfg_expect = 16'h1234;
    logic [15:0]           cfg_run_pat = '0, cfg_total_pat = '0;
    lst_cmd_type [1:0]     cmd = '0;
    logic [7:0]            irq_in = '0;
    logic [15:0]           scan_out, scan_in;
    logic [1:0]            sem_owner, nmi;
    logic [5:0]            scan_en;
    logic                  capture_en, core_isolate, core_rst;
    logic [7:0]            core_irq, irq_log;
    lst_status_type        status;
    int                    failures = 0, n_checks = 0, n_cap = 0, n_rst = 0, n_cyc = 0;

    lst_top #(.CHAIN_LEN(4), .TIMEOUT_CYC(400)) u_lst_top (.clk, .rst_b, .sem_req, .sem_rel, .cfg_wr,
        .cfg_seed, .cfg_expect, .cfg_run_pat, .cfg_total_pat, .cmd, .nmi_clr, .irq_in, .scan_out,
        .sem_owner, .scan_in, .scan_en, .capture_en, .core_isolate, .core_rst, .core_irq, .irq_log,
        .nmi, .status);
    lst_core_model u_lst_core_model (.clk, .scan_en, .scan_in, .scan_out);

    always #5 clk = ~clk;
    always @(negedge clk) begin
        n_cap += int'(capture_en === 1'b1);
        n_rst += int'(core_rst === 1'b1);
        n_cyc++;
        if (n_cyc == 5000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cfg(input int c, input logic [15:0] run, input logic [15:0] tot);
        cfg_run_pat = run;
        cfg_total_pat = tot;
        cfg_wr[c] = 1'b1;
        cyc(1);
        cfg_wr[c] = 1'b0;
    endtask
    // Start pulse, then wait a few cycles for the core to be fenced off
    task automatic run(input int c, input logic rs);
        int n;
        n = 0;
        n_cap = 0;
        n_rst = 0;
        // Caller stands for software that saved context before this strobe
        cmd[c].start = 1'b1;
        cmd[c].restart = rs;
        cyc(1);
        cmd[c] = '0;
        while (core_isolate !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (status.busy !== 1'b0 && n < 600) begin
            cyc(1);
            n++;
        end
        chk(n < 600, "stuck busy");
    endtask

    task automatic t_grant;
        sem_req = 2'b11;
        cyc(2);
        sem_req = 2'b00;
        cyc(1);
        chk(sem_owner === 2'b01, "owner not lowest core");
        cfg(1, 16'h0002, 16'h0004);
        run(1, 1'b1);
        chk(status.busy === 1'b0 && core_isolate === 1'b0, "non-owner started");
    endtask
    task automatic t_run;
        irq_in = 8'h05;
        cfg(0, 16'h0002, 16'h0004);
        run(0, 1'b1);
        // Seed lands one cycle after isolation, together with the scan enables
        cyc(1);
        chk(core_isolate === 1'b1 && scan_in === cfg_seed && scan_en === 6'h3F, "seed not loaded");
        cyc(2);
        chk(core_irq === 8'h00, "irq leaked");
        wait_idle();
        chk(n_cap == 2 && n_rst == 10, "capture or reset count");
        chk(status.run_done === 1'b1 && status.all_done === 1'b0, "run status");
        chk(irq_log === 8'h05, "irq not logged");
        cyc(2);
        chk(core_irq === 8'h05, "irq not restored");
        irq_in = 8'h00;
        cmd[0].log_clr = 1'b1;
        cyc(1);
        cmd[0] = '0;
        cyc(2);
        chk(irq_log === 8'h00 && core_irq === 8'h00, "log not cleared");
    endtask
    task automatic t_cont;
        run(0, 1'b0);
        wait_idle();
        chk(n_cap == 2 && status.all_done === 1'b1, "set not finished");
    endtask
    task automatic t_tmo;
        sem_rel = 2'b01;
        sem_req = 2'b10;
        cyc(1);
        sem_rel = 2'b00;
        cyc(2);
        sem_req = 2'b00;
        chk(sem_owner === 2'b10, "ownership not passed");
        // Set far longer than the watchdog so only the timeout can end the run
        cfg(1, 16'h0000, 16'hFFFF);
        run(1, 1'b1);
        wait_idle();
        chk(status.fail_timeout === 1'b1 && nmi === 2'b11, "timeout not reported");
        chk(status.fail_logic === 1'b0 && status.all_done === 1'b0, "timeout status");
        nmi_clr = 2'b10;
        cyc(1);
        nmi_clr = 2'b00;
        cyc(1);
        chk(nmi === 2'b01, "nmi clear");
    endtask

    initial begin
        cyc(5);
        rst_b = 1'b1;
        cyc(1);
        t_grant();
        t_run();
        t_cont();
        t_tmo();
        stop_test();
    end
endmodule
